// ==== include/base_decoder_defines.svh ====
`ifndef BASE_DECODER_DEFINES_SVH
`define BASE_DECODER_DEFINES_SVH

`define VEC_LO          16'h0000
`define VEC_HI          16'h003f
`define VEC_BRK_IDX     5'h1f
`define VEC_TRAP_IDX    5'h1e
`define VEC_NMI_IDX     5'h01
`define TCALL_BASE      20'h00040
`define DCALL_BASE      20'h00800
`define DCALL_HI        20'h00fff
`define FAST_RAM_LO     16'hfd00
`define FAST_RAM_HI     16'hfeff
`define PERIPHERAL_RAM_LO         16'hdf00
`define PERIPHERAL_RAM_HI         16'hfcff
`define SFR_LO          16'hff00
`define SFR_HI          16'hffff
`define EXT_SFR_LO      16'hffd0
`define EXT_SFR_HI      16'hffdf
`define SHORT_LO        16'hfd20
`define SHORT_HI        16'hfeff
`define GPREG_LO        16'hfe80
`define GPREG_HI        16'hfeff
`define MACRO_LO        16'hfe06
`define MACRO_HI        16'hfe3b
`define LOW_PAGE        4'h0
`define HIGH_PAGE       4'hf
`define ROM_END         20'h20000
`define FETCH_CLOCKS    2
`define FETCH_BYTES     2
`endif

// ==== include/base_decoder_pkg.sv ====
package base_decoder_pkg;
    typedef enum logic [2:0] {
        TGT_ROM        = 3'b000,
        TGT_FAST_RAM   = 3'b001,
        TGT_PERIPH_RAM = 3'b010,
        TGT_SFR        = 3'b011,
        TGT_EXT_SFR    = 3'b100,
        TGT_EXTERNAL   = 3'b101
    } target_e;

    typedef enum logic [1:0] {
        CALL_VECTOR = 2'b00,
        CALL_TABLE  = 2'b01,
        CALL_DIRECT = 2'b10
    } call_kind_e;
endpackage

// ==== include/placement_if.sv ====
`timescale 1ns/1ps
interface placement_if;
    logic selected;
    logic high;
    modport owner (output selected, output high);
    modport user  (input selected, input high);
endinterface

// ==== rtl/base_area_memory_decoder.sv ====
`timescale 1ns/1ps
`include "base_decoder_defines.svh"
module base_area_memory_decoder (
    input  wire logic                         clk,
    input  wire logic                         reset,
    input  wire logic                         acc_valid,
    input  wire logic [19:0]                  acc_addr,
    input  wire logic                         acc_fetch,
    input  wire logic                         sfr_present,
    input  wire logic                         mem_expansion_en,
    input  wire logic                         place_valid,
    input  wire logic                         place_high,
    input  wire logic                         call_valid,
    input  wire base_decoder_pkg::call_kind_e call_kind,
    input  wire logic [10:0]                  call_index,
    input  wire logic                         context_switch,
    input  wire logic                         entry_valid,
    input  wire logic [15:0]                  entry_data,
    output logic                              dec_valid,
    output base_decoder_pkg::target_e         dec_target,
    output logic [15:0]                       dec_offset,
    output logic                              dec_short_direct,
    output logic                              dec_reg_bank_area,
    output logic                              dec_macro_area,
    output logic                              dec_fast_fetch,
    output logic                              fetch_fault,
    output logic                              deadlock,
    output logic                              placed,
    output logic                              placed_high,
    output logic                              entry_addr_valid,
    output logic [19:0]                       entry_addr,
    output logic                              branch_valid,
    output logic [19:0]                       branch_addr,
    output logic                              bank_valid,
    output logic [2:0]                        bank_num
);
    import base_decoder_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Placement
    placement_if pl ();

    placement_latch u_place (
        .clk         (clk),
        .reset       (reset),
        .place_valid (place_valid),
        .place_high  (place_high),
        .pl          (pl)
    );

    ////////////////////////////////////////////////////////////////////////
    // Region decode on the low 16 bits
    localparam int NREG = 7;
    localparam int R_FAST = 0;
    localparam int R_PERIPHERAL_RAM = 1;
    localparam int R_SFR = 2;
    localparam int R_XSFR = 3;
    localparam int R_SHORT = 4;
    localparam int R_GPREG = 5;
    localparam int R_MACRO = 6;
    localparam logic [15:0] LO_TAB [NREG] = '{`FAST_RAM_LO, `PERIPHERAL_RAM_LO, `SFR_LO, `EXT_SFR_LO,
                                              `SHORT_LO, `GPREG_LO, `MACRO_LO};
    localparam logic [15:0] HI_TAB [NREG] = '{`FAST_RAM_HI, `PERIPHERAL_RAM_HI, `SFR_HI, `EXT_SFR_HI,
                                              `SHORT_HI, `GPREG_HI, `MACRO_HI};

    wire logic [15:0]     low16 = acc_addr[15:0];
    wire logic [NREG-1:0] hit;

    genvar g;
    generate
        for (g = 0; g < NREG; g++) begin : g_region
            region_match #(
                .LO (LO_TAB[g]),
                .HI (HI_TAB[g])
            ) u_match (
                .addr (low16),
                .hit  (hit[g])
            );
        end
    endgenerate

    // Unselected placement maps no internal data area at all
    wire logic page_ok       = pl.high ? (acc_addr[19:16] == `HIGH_PAGE)
                                       : (acc_addr[19:16] == `LOW_PAGE);
    wire logic in_window     = pl.selected && page_ok;
    wire logic internal_hit  = in_window && (hit[R_FAST] || hit[R_PERIPHERAL_RAM] || hit[R_SFR]);
    wire logic ext_sfr_sel   = in_window && hit[R_XSFR] && mem_expansion_en;
    wire logic sfr_sel       = in_window && hit[R_SFR] && !ext_sfr_sel;
    wire logic unimpl_sfr    = sfr_sel && !sfr_present;
    wire logic rom_sel       = acc_addr < `ROM_END;
    wire logic take_acc      = acc_valid && !deadlock;

    // Internal area checked first so it shadows ROM and external space
    wire target_e target_next = ext_sfr_sel                    ? TGT_EXT_SFR
                              : sfr_sel                        ? TGT_SFR
                              : (in_window && hit[R_FAST])     ? TGT_FAST_RAM
                              : (in_window && hit[R_PERIPHERAL_RAM])     ? TGT_PERIPH_RAM
                              : rom_sel                        ? TGT_ROM
                              :                                  TGT_EXTERNAL;
    wire logic short_next     = in_window && hit[R_SHORT];
    wire logic gpreg_next     = in_window && hit[R_GPREG];
    wire logic macro_next     = in_window && hit[R_MACRO];
    // Fast RAM and SFR fetches are flagged, not blocked: the core owns recovery
    wire logic fault_next     = acc_fetch && in_window && (hit[R_FAST] || hit[R_SFR]);
    wire logic fast_fetch_nx  = acc_fetch && in_window && hit[R_PERIPHERAL_RAM];
    wire logic [15:0] offset_next = internal_hit ? low16 : 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // Access answer, one cycle after the request
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dec_valid         <= 1'b0;
            dec_target        <= TGT_ROM;
            dec_offset        <= 16'h0000;
            dec_short_direct  <= 1'b0;
            dec_reg_bank_area <= 1'b0;
            dec_macro_area    <= 1'b0;
            dec_fast_fetch    <= 1'b0;
            fetch_fault       <= 1'b0;
        end else begin
            dec_valid         <= take_acc && !unimpl_sfr;
            dec_target        <= target_next;
            dec_offset        <= offset_next;
            dec_short_direct  <= take_acc && short_next;
            dec_reg_bank_area <= take_acc && gpreg_next;
            dec_macro_area    <= take_acc && macro_next;
            dec_fast_fetch    <= take_acc && fast_fetch_nx;
            fetch_fault       <= take_acc && fault_next;
        end
    end

    // Sticky lock; no bus answer can release it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            deadlock <= 1'b0;
        end else if (take_acc && unimpl_sfr) begin
            deadlock <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            placed      <= 1'b0;
            placed_high <= 1'b0;
        end else begin
            placed      <= pl.selected;
            placed_high <= pl.high;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Vector, table call and direct call addressing
    logic pend_reg;
    logic bank_mode_reg;

    wire logic        take_call   = call_valid && !pend_reg;
    wire logic        need_entry  = take_call && (call_kind != CALL_DIRECT);
    wire logic [19:0] vec_loc     = {14'h0000, call_index[4:0], 1'b0};
    wire logic [19:0] tcall_loc   = `TCALL_BASE | {14'h0000, call_index[4:0], 1'b0};
    wire logic [19:0] dcall_tgt   = `DCALL_BASE | {9'h000, call_index};
    wire logic [19:0] loc_next    = (call_kind == CALL_VECTOR) ? vec_loc : tcall_loc;
    wire logic        take_entry  = entry_valid && pend_reg;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pend_reg      <= 1'b0;
            bank_mode_reg <= 1'b0;
        end else if (need_entry) begin
            pend_reg      <= 1'b1;
            bank_mode_reg <= (call_kind == CALL_VECTOR) && context_switch;
        end else if (take_entry) begin
            pend_reg      <= 1'b0;
            bank_mode_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            entry_addr_valid <= 1'b0;
            entry_addr       <= 20'h00000;
        end else begin
            entry_addr_valid <= need_entry;
            entry_addr       <= need_entry ? loc_next : entry_addr;
        end
    end

    // Only 16 bits come from the table, so the page is always the base area
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            branch_valid <= 1'b0;
            branch_addr  <= 20'h00000;
            bank_valid   <= 1'b0;
            bank_num     <= 3'h0;
        end else begin
            branch_valid <= (take_call && (call_kind == CALL_DIRECT)) ||
                            (take_entry && !bank_mode_reg);
            bank_valid   <= take_entry && bank_mode_reg;
            if (take_call && (call_kind == CALL_DIRECT)) begin
                branch_addr <= dcall_tgt;
            end else if (take_entry && !bank_mode_reg) begin
                branch_addr <= {4'h0, entry_data};
            end
            if (take_entry && bank_mode_reg) begin
                bank_num <= entry_data[2:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_deadlock_hold;
        deadlock |=> deadlock && !dec_valid;
    endproperty
    a_deadlock_hold: assert property (p_deadlock_hold) else $error("deadlock released");

    property p_unimpl_locks;
        take_acc && in_window && hit[R_SFR] && !hit[R_XSFR] && !sfr_present |=> deadlock && !dec_valid;
    endproperty
    a_unimpl_locks: assert property (p_unimpl_locks) else $error("unmapped SFR not locked");

    property p_place_once;
        pl.selected |=> pl.selected && (pl.high == $past(pl.high));
    endproperty
    a_place_once: assert property (p_place_once) else $error("placement changed");

    property p_unplaced;
        take_acc && !pl.selected |=> dec_valid && (dec_target == TGT_ROM || dec_target == TGT_EXTERNAL);
    endproperty
    a_unplaced: assert property (p_unplaced) else $error("internal area before placement");

    property p_sfr_shadow;
        take_acc && pl.selected && !pl.high && acc_addr[19:8] == 12'h0ff && sfr_present
            && !(acc_addr[7:4] == 4'hd && mem_expansion_en) |=> dec_target == TGT_SFR;
    endproperty
    a_sfr_shadow: assert property (p_sfr_shadow) else $error("SFR not decoded");

    property p_ext_sfr;
        take_acc && in_window && acc_addr[15:4] == 12'hffd |=>
            (dec_target == TGT_EXT_SFR) == $past(mem_expansion_en);
    endproperty
    a_ext_sfr: assert property (p_ext_sfr) else $error("external SFR window wrong");

    property p_high_shift;
        take_acc && pl.selected && pl.high && acc_addr[19:9] == 11'h7fe && acc_addr[8] == 1'b1 |=>
            dec_target == TGT_FAST_RAM && dec_offset == $past(acc_addr[15:0]);
    endproperty
    a_high_shift: assert property (p_high_shift) else $error("high placement shift wrong");

    property p_peripheral_ram_fetch;
        take_acc && acc_fetch && in_window && hit[R_PERIPHERAL_RAM] |=> dec_fast_fetch && !fetch_fault;
    endproperty
    a_peripheral_ram_fetch: assert property (p_peripheral_ram_fetch) else $error("peripheral RAM fetch not fast");

    property p_vector_loc;
        take_call && call_kind == CALL_VECTOR |=> entry_addr_valid && entry_addr[19:6] == 14'h0000
            && entry_addr[5:1] == $past(call_index[4:0]);
    endproperty
    a_vector_loc: assert property (p_vector_loc) else $error("vector location wrong");

    property p_table_loc;
        take_call && call_kind == CALL_TABLE |=> entry_addr >= `TCALL_BASE && entry_addr <= 20'h0007f;
    endproperty
    a_table_loc: assert property (p_table_loc) else $error("table call location wrong");

    property p_direct_range;
        take_call && call_kind == CALL_DIRECT |=> branch_valid && branch_addr >= `DCALL_BASE
            && branch_addr <= `DCALL_HI;
    endproperty
    a_direct_range: assert property (p_direct_range) else $error("direct call out of range");

    property p_base_branch;
        branch_valid |-> branch_addr[19:16] == 4'h0 && !bank_valid;
    endproperty
    a_base_branch: assert property (p_base_branch) else $error("branch left base area");

    property p_bank_entry;
        take_entry && bank_mode_reg |=> bank_valid && !branch_valid && bank_num == $past(entry_data[2:0]);
    endproperty
    a_bank_entry: assert property (p_bank_entry) else $error("bank number not delivered");

    // Raw address bounds, not the hit vector, so a bad table bound shows
    property p_fast_ram;
        take_acc && in_window && acc_addr[15:0] >= `FAST_RAM_LO && acc_addr[15:0] <= `FAST_RAM_HI |=>
            dec_valid && dec_target == TGT_FAST_RAM && dec_offset == $past(acc_addr[15:0]);
    endproperty
    a_fast_ram: assert property (p_fast_ram) else $error("fast RAM not decoded");

    property p_peripheral_ram;
        take_acc && in_window && acc_addr[15:0] >= `PERIPHERAL_RAM_LO && acc_addr[15:0] <= `PERIPHERAL_RAM_HI |=>
            dec_valid && dec_target == TGT_PERIPH_RAM;
    endproperty
    a_peripheral_ram: assert property (p_peripheral_ram) else $error("peripheral RAM not decoded");

    property p_sfr_range;
        take_acc && in_window && acc_addr[15:8] == 8'hff && sfr_present && !mem_expansion_en |=>
            dec_valid && dec_target == TGT_SFR;
    endproperty
    a_sfr_range: assert property (p_sfr_range) else $error("SFR range not decoded");

    property p_vec_plain;
        take_acc && acc_addr[19:6] == 14'h0000 |=> dec_valid && dec_target == TGT_ROM;
    endproperty
    a_vec_plain: assert property (p_vec_plain) else $error("vector area not plain memory");

    property p_short_range;
        dec_short_direct |-> dec_valid && dec_target == TGT_FAST_RAM && dec_offset >= `SHORT_LO;
    endproperty
    a_short_range: assert property (p_short_range) else $error("short direct outside fast RAM");

    property p_bank_area;
        dec_reg_bank_area |-> dec_short_direct && dec_offset[15:7] == 9'h1fd;
    endproperty
    a_bank_area: assert property (p_bank_area) else $error("register bank area wrong");

    property p_macro_area;
        dec_macro_area |-> dec_short_direct && dec_offset >= `MACRO_LO && dec_offset <= `MACRO_HI;
    endproperty
    a_macro_area: assert property (p_macro_area) else $error("macro service area wrong");

    property p_idle_offset;
        dec_target == TGT_ROM || dec_target == TGT_EXTERNAL |-> dec_offset == 16'h0000;
    endproperty
    a_idle_offset: assert property (p_idle_offset) else $error("offset on outside target");

    property p_high_page;
        take_acc && pl.selected && pl.high && acc_addr[19:16] == `LOW_PAGE |=>
            dec_valid && dec_target == TGT_ROM;
    endproperty
    a_high_page: assert property (p_high_page) else $error("low page still internal");

    property p_placed_follow;
        pl.selected |=> placed && placed_high == $past(pl.high);
    endproperty
    a_placed_follow: assert property (p_placed_follow) else $error("placement state not shown");

    property p_table_slot;
        take_call && call_kind == CALL_TABLE |=> entry_addr_valid && entry_addr[5:1] == $past(call_index[4:0]);
    endproperty
    a_table_slot: assert property (p_table_slot) else $error("table slot wrong");

    // A pending table read blocks new calls, so one answer per call
    property p_call_busy;
        pend_reg && !entry_valid |=> !branch_valid && !bank_valid && !entry_addr_valid;
    endproperty
    a_call_busy: assert property (p_call_busy) else $error("answer while table read pending");
endmodule

// ==== rtl/placement_latch.sv ====
`timescale 1ns/1ps
module placement_latch (
    input  wire logic   clk,
    input  wire logic   reset,
    input  wire logic   place_valid,
    input  wire logic   place_high,
    placement_if.owner  pl
);
    logic selected_reg;
    logic high_reg;

    // One-time register; only reset reopens it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            selected_reg <= 1'b0;
            high_reg     <= 1'b0;
        end else if (place_valid && !selected_reg) begin
            selected_reg <= 1'b1;
            high_reg     <= place_high;
        end
    end

    assign pl.selected = selected_reg;
    assign pl.high     = high_reg;
endmodule

// ==== rtl/region_match.sv ====
`timescale 1ns/1ps
module region_match #(
    parameter logic [15:0] LO = 16'h0000,
    parameter logic [15:0] HI = 16'hffff
) (
    input  wire logic [15:0] addr,
    output wire logic        hit
);
    assign hit = (addr >= LO) && (addr <= HI);
endmodule

// ==== sim/table_word_model.sv ====
`timescale 1ns/1ps
module table_word_model #(
    parameter int DELAY = 3
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        entry_addr_valid,
    input  wire logic [19:0] entry_addr,
    output logic             entry_valid,
    output logic [15:0]      entry_data
);
    ////////////////////////////////////////////////////////////////
    logic [15:0] word_reg;
    int          wait_reg;

    // Slot words differ per address, so a wrong slot shows up
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            word_reg    <= 16'h0000;
            wait_reg    <= 0;
            entry_valid <= 1'b0;
            entry_data  <= 16'hffff;
        end else begin
            entry_valid <= 1'b0;
            entry_data  <= ~entry_data; // Released lines toggle, never hold the last word
            if (entry_addr_valid) begin
                word_reg <= entry_addr[15:0] ^ 16'h0a5a;
                wait_reg <= DELAY;
            end else if (wait_reg > 1) begin
                wait_reg <= wait_reg - 1;
            end else if (wait_reg == 1) begin
                entry_valid <= 1'b1;
                entry_data  <= word_reg;
                wait_reg    <= 0;
            end
        end
    end
endmodule

// ==== sim/test_base_area_memory_decoder.sv ====
`timescale 1ns/1ps
module test_base_area_memory_decoder;
    import base_decoder_pkg::*;
    typedef struct {
        logic [19:0] a;
        logic [2:0]  ctl;
        target_e     t;
        logic [4:0]  fl;
    } row_s;
    ////////////////////////////////////////////////////////////////
    logic        clk, reset, acc_valid, acc_fetch, sfr_present, mem_expansion_en;
    logic        place_valid, place_high, call_valid, context_switch, entry_valid;
    logic [19:0] acc_addr, entry_addr, branch_addr;
    call_kind_e  call_kind;
    logic [10:0] call_index;
    logic [15:0] entry_data, dec_offset;
    target_e     dec_target;
    logic        dec_valid, dec_short_direct, dec_reg_bank_area, dec_macro_area, dec_fast_fetch;
    logic        fetch_fault, deadlock, placed, placed_high, entry_addr_valid, branch_valid, bank_valid;
    logic [2:0]  bank_num;
    int          miscompares, checks_done, cycles;
    // Control bits: fetch, sfr present, expansion; flags: short, bank, macro, fast, fault
    row_s rows[27] = '{
        '{20'h00010, 3'b000, TGT_ROM, 5'h00}, '{20'h0003e, 3'b100, TGT_ROM, 5'h00},
        '{20'h0df00, 3'b100, TGT_PERIPH_RAM, 5'h02}, '{20'h0fcff, 3'b000, TGT_PERIPH_RAM, 5'h00},
        '{20'h0fd00, 3'b000, TGT_FAST_RAM, 5'h00}, '{20'h0fd20, 3'b000, TGT_FAST_RAM, 5'h10},
        '{20'h0fe06, 3'b000, TGT_FAST_RAM, 5'h14}, '{20'h0fe3b, 3'b000, TGT_FAST_RAM, 5'h14},
        '{20'h0fe3c, 3'b000, TGT_FAST_RAM, 5'h10}, '{20'h0fe80, 3'b000, TGT_FAST_RAM, 5'h18},
        '{20'h0feff, 3'b000, TGT_FAST_RAM, 5'h18}, '{20'h0fd00, 3'b100, TGT_FAST_RAM, 5'h01},
        '{20'h0ff00, 3'b010, TGT_SFR, 5'h00}, '{20'h0ff00, 3'b110, TGT_SFR, 5'h01},
        '{20'h0ffd0, 3'b001, TGT_EXT_SFR, 5'h00}, '{20'h0ffdf, 3'b001, TGT_EXT_SFR, 5'h00},
        '{20'h0ffe0, 3'b011, TGT_SFR, 5'h00}, '{20'h0ffd0, 3'b010, TGT_SFR, 5'h00},
        '{20'h0deff, 3'b000, TGT_ROM, 5'h00}, '{20'h1ffff, 3'b000, TGT_ROM, 5'h00},
        '{20'h20000, 3'b000, TGT_EXTERNAL, 5'h00}, '{20'hffd00, 3'b000, TGT_EXTERNAL, 5'h00},
        '{20'hffd00, 3'b000, TGT_FAST_RAM, 5'h00}, '{20'hfff00, 3'b010, TGT_SFR, 5'h00},
        '{20'hfffd0, 3'b001, TGT_EXT_SFR, 5'h00}, '{20'hfdf00, 3'b100, TGT_PERIPH_RAM, 5'h02},
        '{20'h0fd00, 3'b000, TGT_ROM, 5'h00}};

    base_area_memory_decoder base_area_memory_decoder_i (
        .clk(clk), .reset(reset), .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_fetch(acc_fetch),
        .sfr_present(sfr_present), .mem_expansion_en(mem_expansion_en), .place_valid(place_valid),
        .place_high(place_high), .call_valid(call_valid), .call_kind(call_kind), .call_index(call_index),
        .context_switch(context_switch), .entry_valid(entry_valid), .entry_data(entry_data),
        .dec_valid(dec_valid), .dec_target(dec_target), .dec_offset(dec_offset),
        .dec_short_direct(dec_short_direct), .dec_reg_bank_area(dec_reg_bank_area),
        .dec_macro_area(dec_macro_area), .dec_fast_fetch(dec_fast_fetch), .fetch_fault(fetch_fault),
        .deadlock(deadlock), .placed(placed), .placed_high(placed_high),
        .entry_addr_valid(entry_addr_valid), .entry_addr(entry_addr), .branch_valid(branch_valid),
        .branch_addr(branch_addr), .bank_valid(bank_valid), .bank_num(bank_num));
    table_word_model #(.DELAY(3)) table_word_model_i (
        .clk(clk), .reset(reset), .entry_addr_valid(entry_addr_valid), .entry_addr(entry_addr),
        .entry_valid(entry_valid), .entry_data(entry_data));
    ////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk_val(input logic [19:0] g, input logic [19:0] e);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk_bit(input logic g, input logic e);
        chk_val({19'h0, g}, {19'h0, e});
    endtask
    task automatic chk_tgt(input target_e g, input target_e e);
        chk_val({17'h0, g}, {17'h0, e});
    endtask
    // Inputs change only by NBA on the edge; results read 1 ns after the answering edge
    task automatic go(input logic [19:0] a, input logic [2:0] c);
        @(posedge clk);
        acc_valid <= 1'b1;
        acc_addr  <= a;
        {acc_fetch, sfr_present, mem_expansion_en} <= c;
        @(posedge clk);
        acc_valid <= 1'b0;
        #1;
    endtask
    task automatic check_row(input row_s r);
        go(r.a, r.ctl);
        chk_bit(dec_valid, 1'b1);
        chk_tgt(dec_target, r.t);
        if (r.t inside {TGT_FAST_RAM, TGT_PERIPH_RAM, TGT_SFR})
            chk_val({4'h0, dec_offset}, {4'h0, r.a[15:0]});
        chk_val({15'h0, dec_short_direct, dec_reg_bank_area, dec_macro_area, dec_fast_fetch, fetch_fault},
                {15'h0, r.fl});
    endtask
    task automatic place(input logic h);
        @(posedge clk);
        place_valid <= 1'b1;
        place_high  <= h;
        @(posedge clk);
        place_valid <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    // Non-direct calls: x is the table slot; the branch, or with cs the bank number, comes from the slot word
    task automatic do_call(input call_kind_e k, input logic [10:0] idx, input logic cs, input logic [19:0] x);
        int n;
        logic [19:0] w;
        w = {4'h0, x[15:0] ^ 16'h0a5a};
        @(posedge clk);
        call_valid     <= 1'b1;
        call_kind      <= k;
        call_index     <= idx;
        context_switch <= cs;
        @(posedge clk);
        call_valid <= 1'b0;
        #1;
        if (k == CALL_DIRECT) begin
            chk_bit(branch_valid, 1'b1);
            chk_val(branch_addr, x);
        end else begin
            chk_bit(entry_addr_valid, 1'b1);
            chk_val(entry_addr, x);
            n = 0;
            while (branch_valid !== 1'b1 && bank_valid !== 1'b1 && n < 20) begin
                @(posedge clk);
                #1;
                n++;
            end
            chk_bit(cs ? bank_valid : branch_valid, 1'b1);
            if (cs)
                chk_val({17'h0, bank_num}, {17'h0, w[2:0]});
            else
                chk_val(branch_addr, w);
        end
    endtask
    task automatic do_reset();
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        #1;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Whole run is about 130 cycles; the ceiling of 3000 leaves ample margin
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            stop_test();
        end
    end
    initial begin
        {reset, acc_valid, acc_fetch, sfr_present, mem_expansion_en} = 5'b10000;
        {place_valid, place_high, call_valid, context_switch} = 4'b0000;
        acc_addr = 20'h00000;
        call_kind = CALL_VECTOR;
        call_index = 11'h000;
        miscompares = 0;
        checks_done = 0;
        cycles = 0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk_bit(placed, 1'b0);
        check_row(rows[26]);
        place(1'b0);
        chk_val({18'h0, placed, placed_high}, 20'h00002);
        for (int i = 0; i < 22; i++)
            check_row(rows[i]);
        place(1'b1);
        chk_bit(placed_high, 1'b0);
        check_row(rows[4]);
        do_call(CALL_DIRECT, 11'h000, 1'b0, 20'h00800);
        do_call(CALL_DIRECT, 11'h7ff, 1'b0, 20'h00fff);
        do_call(CALL_VECTOR, 11'h01f, 1'b0, 20'h0003e);
        do_call(CALL_VECTOR, 11'h01e, 1'b0, 20'h0003c);
        do_call(CALL_VECTOR, 11'h001, 1'b0, 20'h00002);
        do_call(CALL_TABLE, 11'h000, 1'b0, 20'h00040);
        do_call(CALL_TABLE, 11'h01f, 1'b0, 20'h0007e);
        do_call(CALL_VECTOR, 11'h006, 1'b1, 20'h0000c);
        // Missing SFR locks the decoder; only reset frees it
        go(20'h0ff10, 3'b000);
        chk_val({18'h0, dec_valid, deadlock}, 20'h00001);
        go(20'h0fd00, 3'b000);
        chk_val({18'h0, dec_valid, deadlock}, 20'h00001);
        do_reset();
        chk_val({17'h0, deadlock, placed, placed_high}, 20'h00000);
        place(1'b1);
        chk_bit(placed_high, 1'b1);
        for (int i = 22; i < 27; i++)
            check_row(rows[i]);
        stop_test();
    end
endmodule
